// ==== logic/tct_pkg.sv ====
// Overview of operation
// - Sync output pulses at 8kHz on backplane clock
// - Sync plus backplane clock act as bus master
// - Sampled signaling bits strobed out on tx_sig_bit with tx_sig_valid
// - Store off: sample on line clock fall
// - Store on: sample on system clock fall
// - Accept signaling stream up to 16.384MHz
// - Block output level programmable per time slot
// - Block output follows clock chosen by store
// - Gapped mode: N x 64kHz fractional clock
// - Channel clock mode: high during channel LSB
// - Gapped clock enable bit selects mode
// - Channel clock timed by store-selected clock
package tct_pkg;
  localparam logic [31:0] OFS_CTRL      = 32'h0000_0000;
  localparam logic [31:0] OFS_STATUS    = 32'h0000_0004;
  localparam logic [31:0] OFS_SYNC_DIV  = 32'h0000_0008;
  localparam logic [31:0] OFS_BLOCK     = 32'h0000_0010;
  localparam logic [31:0] OFS_GAP       = 32'h0000_0014;
  localparam logic [31:0] OFS_SIG_DATA  = 32'h0000_0018;
  localparam int          CTRL_E1_BIT    = 0;
  localparam int          CTRL_ES_BIT    = 1;
  localparam int          CTRL_GAP_BIT   = 2;
  localparam int          CTRL_SYNCO_BIT = 3;
  localparam int          CTRL_SIGEN_BIT = 4;
  localparam int          CTRL_FBIT_BIT  = 5;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [15:0] SYNC_DIV_RESET = 16'h0100;
  localparam logic [7:0]  T1_BITS        = 8'hC0;
  localparam logic [7:0]  E1_BITS        = 8'hFF;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  typedef struct packed {
    logic line_clk;
    logic sys_clk;
    logic bp_clk;
    logic sig_in;
  } tct_pins_s;
endpackage : tct_pkg

// ==== logic/tct_top.sv ====
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module tct_top
  import tct_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire tct_pins_s   pins,
  input  wire logic        tx_system_sync_in,
  output logic             tx_system_sync_out,
  output logic             tx_system_sync_oe,
  output logic             tx_channel_block_out,
  output logic             tx_channel_clock_out,
  output logic             tx_sig_bit,
  output logic             tx_sig_valid
);
  logic [7:0]  ctrl_r;
  logic [15:0] sync_div_r;
  logic [31:0] block_r;
  logic [31:0] gap_r;
  logic [31:0] sig_shift_r;

  logic [3:0]  s1_r;
  logic [3:0]  s2_r;
  logic [3:0]  s3_r;
  logic        ssi1_r;
  logic        ssi2_r;
  logic        ssi3_r;

  logic [15:0] bp_cnt_r;
  logic [7:0]  bit_cnt_r;
  logic [7:0]  frame_bits;
  logic        es_on;
  logic        e1;
  logic        line_transmit_clock_fall;
  logic        line_transmit_clock_rise;
  logic        bp_rise;
  logic        frm_start;
  logic [4:0]  chan;
  logic [2:0]  bpos;
  logic        fbit;
  logic        chan_sel;

  logic        aw_hold_r;
  logic        w_hold_r;
  logic [31:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;

  logic [31:0] rd_mux;
  logic        rd_ok;
  logic [31:0] status_w;

  // Two flops before use; pins are asynchronous to aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r   <= 4'h0;
      s2_r   <= 4'h0;
      s3_r   <= 4'h0;
      ssi1_r <= 1'b0;
      ssi2_r <= 1'b0;
      ssi3_r <= 1'b0;
    end else begin
      s1_r   <= pins;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      ssi1_r <= tx_system_sync_in;
      ssi2_r <= ssi1_r;
      ssi3_r <= ssi2_r;
    end
  end

  assign es_on = ctrl_r[CTRL_ES_BIT];
  assign e1    = ctrl_r[CTRL_E1_BIT];
  assign frame_bits = e1 ? E1_BITS : T1_BITS;

  // line clock fall when store off
  // system clock fall when store on
  always_comb begin
    line_transmit_clock_fall = 1'b0;
    line_transmit_clock_rise = 1'b0;
    if (es_on) begin
      line_transmit_clock_fall = s3_r[2] & ~s2_r[2];
      line_transmit_clock_rise = ~s3_r[2] & s2_r[2];
    end else begin
      line_transmit_clock_fall = s3_r[3] & ~s2_r[3];
      line_transmit_clock_rise = ~s3_r[3] & s2_r[3];
    end
  end

  // Sync divider runs on the backplane clock alone
  assign bp_rise = ~s3_r[1] & s2_r[1];

  // external sync aligns frame with store on and sync output off
  assign frm_start = es_on && !ctrl_r[CTRL_SYNCO_BIT] && ssi2_r && !ssi3_r;

  // Bit position inside the frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_cnt_r <= 8'h00;
    end else if (frm_start) begin
      bit_cnt_r <= 8'h00;
    end else if (line_transmit_clock_rise) begin
      bit_cnt_r <= (bit_cnt_r >= frame_bits) ? 8'h00 : bit_cnt_r + 8'h01;
    end
  end

  // T1 frame starts with F-bit, then 24 slots of 8 bits
  assign fbit = !e1 && (bit_cnt_r == 8'h00);
  always_comb begin
    logic [7:0] b;
    b    = e1 ? bit_cnt_r : bit_cnt_r - 8'h01;
    chan = b[7:3];
    bpos = b[2:0];
  end

  assign chan_sel = fbit ? ctrl_r[CTRL_FBIT_BIT] : gap_r[chan];

  // outputs move on the selected clock edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_channel_block_out <= 1'b0;
      tx_channel_clock_out <= 1'b0;
    end else if (line_transmit_clock_rise) begin
      tx_channel_block_out <= fbit ? 1'b0 : block_r[chan];
      if (ctrl_r[CTRL_GAP_BIT]) begin
        // gated clock high half follows the store-selected clock
        tx_channel_clock_out <= chan_sel;
      end else begin
        tx_channel_clock_out <= !fbit && (bpos == 3'h7);
      end
    end else if (line_transmit_clock_fall && ctrl_r[CTRL_GAP_BIT]) begin
      tx_channel_clock_out <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_sig_bit   <= 1'b0;
      tx_sig_valid <= 1'b0;
      sig_shift_r  <= 32'h0000_0000;
    end else begin
      tx_sig_valid <= 1'b0;
      if (line_transmit_clock_fall && ctrl_r[CTRL_SIGEN_BIT]) begin
        tx_sig_bit   <= s2_r[0];
        tx_sig_valid <= 1'b1;
        sig_shift_r  <= {sig_shift_r[30:0], s2_r[0]};
      end
    end
  end

  // sync output, one backplane period per frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bp_cnt_r           <= 16'h0000;
      tx_system_sync_out <= 1'b0;
      tx_system_sync_oe  <= 1'b0;
    end else begin
      tx_system_sync_oe <= ctrl_r[CTRL_SYNCO_BIT];
      // Counting backplane edges keeps the pulse one
      // backplane period wide at any backplane rate
      if (bp_rise) begin
        bp_cnt_r           <= (bp_cnt_r >= sync_div_r - 16'h0001) ? 16'h0000 :
                              bp_cnt_r + 16'h0001;
        tx_system_sync_out <= ctrl_r[CTRL_SYNCO_BIT] && (bp_cnt_r == 16'h0000);
      end
    end
  end

  // AXI4-Lite write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= 32'h0000_0000;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      ctrl_r        <= CTRL_RESET;
      sync_div_r    <= SYNC_DIV_RESET;
      block_r       <= 32'h0000_0000;
      gap_r         <= 32'h0000_0000;
    end else begin
      // Address and data arrive in either order; neither
      // is taken again while the response still stands
      s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready  <= !w_hold_r && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (aw_hold_r && w_hold_r) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= RESP_OKAY;
        unique case (awaddr_r)
          OFS_CTRL: begin
            if (wstrb_r[0]) ctrl_r <= wdata_r[7:0];
          end
          OFS_SYNC_DIV: begin
            if (wstrb_r[0]) sync_div_r[7:0] <= wdata_r[7:0];
            if (wstrb_r[1]) sync_div_r[15:8] <= wdata_r[15:8];
          end
          OFS_BLOCK: begin
            for (int i = 0; i < 4; i++) begin
              if (wstrb_r[i]) block_r[i*8 +: 8] <= wdata_r[i*8 +: 8];
            end
          end
          OFS_GAP: begin
            for (int i = 0; i < 4; i++) begin
              if (wstrb_r[i]) gap_r[i*8 +: 8] <= wdata_r[i*8 +: 8];
            end
          end
          OFS_STATUS, OFS_SIG_DATA: ;
          default: s_axi_bresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Live snapshot; bit position and channel as the slot counter sees them
  always_comb begin
    status_w       = 32'h0000_0000;
    status_w[2:0]  = bpos;
    status_w[7:3]  = chan;
    status_w[8]    = tx_channel_block_out;
    status_w[9]    = tx_channel_clock_out;
    status_w[10]   = tx_system_sync_out;
  end

  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (s_axi_araddr)
      OFS_CTRL:     rd_mux = {24'h00_0000, ctrl_r};
      OFS_STATUS:   rd_mux = status_w;
      OFS_SYNC_DIV: rd_mux = {16'h0000, sync_div_r};
      OFS_BLOCK:    rd_mux = block_r;
      OFS_GAP:      rd_mux = gap_r;
      OFS_SIG_DATA: rd_mux = sig_shift_r;
      default:      rd_ok  = 1'b0;
    endcase
  end

  // AXI4-Lite read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      // Data captured at the address handshake
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : tct_top

// ==== verif/tct_far_model.sv ====
`timescale 1ns/1ps
module tct_far_model
  import tct_pkg::*;
(
  output tct_pins_s pins,
  output logic      sync_pulse
);
  logic       line = 0, sys = 0, bp = 0, sig = 0;
  logic [7:0] n = 0;
  assign pins = '{line_clk: line, sys_clk: sys, bp_clk: bp, sig_in: sig};
  initial forever #62.5 line = ~line;
  initial #20 forever #62.5 sys = ~sys;
  initial #7 forever #62.5 bp = ~bp;
  always @(posedge line) sig <= n[1] ^ n[4];
  always @(posedge sys) n <= n + 8'h01;
  assign sync_pulse = n == 8'h00;
endmodule : tct_far_model

// ==== verif/tct_top_props.sv ====
`timescale 1ns/1ps
module tct_top_props
  import tct_pkg::*;
(
  input wire logic      aclk,
  input wire logic      aresetn,
  input wire logic      s_axi_bvalid,
  input wire logic      s_axi_bready,
  input wire logic      s_axi_rvalid,
  input wire logic      s_axi_rready,
  input wire tct_pins_s pins,
  input wire logic      tx_system_sync_out,
  input wire logic      tx_channel_clock_out,
  input wire logic      tx_sig_bit,
  input wire logic      tx_sig_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // One backplane period is 15 or 16 cycles
  sequence s_sync_hi;
    tx_system_sync_out [*8] ##1 tx_system_sync_out [*7];
  endsequence
  sequence s_clk_hi;
    tx_channel_clock_out [*5];
  endsequence
  AST_BV_DROP: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  AST_RV_DROP: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not released");
  AST_SYNC_WIDTH: assert property (
    $rose(tx_system_sync_out) |-> s_sync_hi ##[1:2] !tx_system_sync_out)
    else $error("sync pulse width wrong");
  AST_SYNC_GAP: assert property (
    $fell(tx_system_sync_out) |=> !tx_system_sync_out [*8])
    else $error("sync pulses too close");
  AST_CHCLK_HI: assert property (
    $rose(tx_channel_clock_out) |-> s_clk_hi ##[1:12] !tx_channel_clock_out)
    else $error("channel clock high time wrong");
  AST_CHCLK_LO: assert property (
    $fell(tx_channel_clock_out) |=> !tx_channel_clock_out [*5])
    else $error("channel clock low time short");
  AST_SIG_PULSE: assert property (
    tx_sig_valid |=> !tx_sig_valid)
    else $error("signaling strobe too long");
  AST_SIG_BIT: assert property (
    tx_sig_valid |-> tx_sig_bit == $past(pins.sig_in, 3))
    else $error("signaling bit not the sampled one");
endmodule : tct_top_props
bind tct_top tct_top_props u_props (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rvalid, .s_axi_rready, .pins, .tx_system_sync_out, .tx_channel_clock_out,
  .tx_sig_bit, .tx_sig_valid);

// ==== verif/tct_top_tb.sv ====
`timescale 1ns/1ps
module tct_top_tb;
  import tct_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, tx_system_sync_in, tx_system_sync_out;
  logic tx_system_sync_oe, tx_channel_block_out, tx_channel_clock_out, tx_sig_bit, tx_sig_valid;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bq[$];
  logic [33:0] rq[$];
  tct_pins_s   pins;
  int n_mismatch = 0, n_checks = 0, n, i;
  int tsel[9] = '{2, 2, 2, 1, 1, 1, 1, 1, 1};
  int tctl[9] = '{17, 19, 1, 1, 3, 5, 5, 36, 5};
  int tcyc[9] = '{625, 625, 625, 1000, 1000, 1000, 1000, 3200, 4000};
  int tlo[9]  = '{39, 39, 0, 7, 7, 63, 0, 1, 14};
  int thi[9]  = '{41, 41, 0, 9, 9, 65, 0, 2, 17};
  tct_top dut (.*);
  tct_far_model far (.pins(pins), .sync_pulse(tx_system_sync_in));
  initial forever #4 aclk = ~aclk;
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk_bus(string nm, logic [33:0] e, logic [33:0] s);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk_bus
  task automatic chk_cnt(string nm, int lo, int hi, int s);
    n_checks++;
    if (s < lo || s > hi) begin
      n_mismatch++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, s);
    end
  endtask : chk_cnt
  task automatic hang(int k);
    if (k >= 300) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : hang
  task automatic wr(logic [31:0] a, logic [31:0] d, logic [1:0] er);
    int k;
    bq.push_back(er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (k = 0; k < 300; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'h0;
    @(posedge aclk);
    hang(k);
  endtask : wr
  task automatic rd(logic [31:0] a, logic [1:0] er, logic [31:0] ed);
    int k;
    rq.push_back({er, ed});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (k = 0; k < 300; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'h0;
    @(posedge aclk);
    hang(k);
  endtask : rd
  // Rising edges of one output over a window
  task automatic cnt(int sel, int cyc, output int c);
    logic p, v;
    c = 0;
    p = 1'h1;
    repeat (cyc) begin
      @(posedge aclk);
      v = sel == 0 ? tx_system_sync_out : sel == 1 ? tx_channel_clock_out : tx_sig_valid;
      if (v === 1'h1 && p === 1'h0) c++;
      p = v;
    end
  endtask : cnt
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
      chk_bus("bresp", {32'h0000_0000, bq.pop_front()}, {32'h0000_0000, s_axi_bresp});
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
      chk_bus("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
  end
  initial begin
    n = $urandom(95967);
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    rd(OFS_CTRL, RESP_OKAY, 32'h0000_0000);
    rd(OFS_SYNC_DIV, RESP_OKAY, 32'h0000_0100);
    rd(32'h0000_000C, RESP_SLVERR, 32'h0000_0000);
    wr(32'h0000_000C, 32'h0000_0001, RESP_SLVERR);
    n = $urandom;
    wr(OFS_GAP, 32'(n), RESP_OKAY);
    rd(OFS_GAP, RESP_OKAY, 32'(n));
    $display("test registers done");
    wr(OFS_SYNC_DIV, 32'h0000_0004, RESP_OKAY);
    wr(OFS_CTRL, 32'h0000_0008, RESP_OKAY);
    cnt(0, 625, n);
    chk_cnt("sync pulses", 9, 11, n);
    chk_bus("sync enable", 34'h1, {33'h0, tx_system_sync_oe});
    $display("test sync done");
    for (i = 0; i < 9; i++) begin
      wr(OFS_GAP, i == 5 ? 32'hFFFF_FFFF : {30'h0, {2{i == 8}}}, RESP_OKAY);
      wr(OFS_CTRL, 32'(tctl[i]), RESP_OKAY);
      cnt(tsel[i], tcyc[i], n);
      chk_cnt("pulse count", tlo[i], thi[i], n);
    end
    $display("test clocks done");
    wr(OFS_CTRL, 32'h0000_0003, RESP_OKAY);
    for (i = 0; i < 2; i++) begin
      wr(OFS_BLOCK, i == 0 ? 32'hFFFF_FFFF : 32'h0000_0000, RESP_OKAY);
      repeat (300) @(posedge aclk);
      chk_bus("block level", {33'h0, i == 0}, {33'h0, tx_channel_block_out});
    end
    $display("test block done");
    give_verdict();
  end
endmodule : tct_top_tb
